// >>> hcbs_cfg.svh
// Purpose: constants for host control and boot strap block
// Assumes: 25 MHz clock
// Notes: register offsets are byte addresses on APB
`ifndef HCBS_CFG_SVH
`define HCBS_CFG_SVH
`define HCBS_OFS_CTRL 12'h000
`define HCBS_OFS_STAT 12'h004
`define HCBS_OFS_LAMP 12'h008
`define HCBS_OFS_RXD 12'h00C
`define HCBS_OFS_TXD 12'h010
`define HCBS_CLK_HZ 25000000
`define HCBS_BAUD 115200
`define HCBS_LAMP_DIV 25000
`define HCBS_RST_MIN_NS 63
`endif

// >>> hcbs_pkg.sv
// Purpose: types for host control and boot strap block
// Assumes: nothing
// Notes: none
package hcbs_pkg;
	typedef enum logic [2:0] {
		HCBS_SLEEP = 3'b001,
		HCBS_AWAKE = 3'b010,
		HCBS_FLASH = 3'b100
	} hcbs_mode_t;
	typedef struct packed {
		logic boot_first;
		logic boot_second;
		logic code_source;
	} hcbs_strap_t;
	typedef enum logic [2:0] {
		HCBS_ST_STANDBY = 3'h0,
		HCBS_ST_INQUIRY = 3'h1,
		HCBS_ST_LINK = 3'h2,
		HCBS_ST_LINKBACK = 3'h3,
		HCBS_ST_LOWBAT = 3'h4,
		HCBS_ST_PAGE = 3'h5,
		HCBS_ST_CHARGE = 3'h6
	} hcbs_state_t;
endpackage : hcbs_pkg

// >>> hcbs_top.sv
// Purpose: host wake, command uart, straps and status lamps
// Assumes: inputs synchronous to clock; rst_b is the module reset pin
// Notes: uart is 8N1; lamp patterns are 8-step masks per state
`timescale 1ns/1ps
`include "hcbs_cfg.svh"
module hcbs_top
	import hcbs_pkg::*;
#(
	parameter int BAUD_DIV = `HCBS_CLK_HZ / `HCBS_BAUD,
	parameter int LAMP_DIV = `HCBS_LAMP_DIV
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic wake_key_input,
	output logic host_wake_output,
	input wire hcbs_strap_t strap_in,
	output logic rom_mode,
	output logic application_run_mode,
	output logic status_lamp_one,
	output logic status_lamp_two,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// pads carry pull-ups; strap_in is the pad level, undriven reads 1
	hcbs_mode_t mode_q, mode_d;
	hcbs_strap_t strap_q, strap_d;
	logic strap_done_q, strap_done_d;
	logic rom_q, rom_d, app_q, app_d;
	// control: [0] sleep request, [1] host wake request, [4:2] lamp state
	logic [4:0] ctrl_q, ctrl_d;
	logic [15:0] lamp_pat_q [0:6];
	logic [15:0] lamp_pat_d [0:6];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [7:0] rxd_q, rxd_d;
	logic rx_full_q, rx_full_d;
	logic [9:0] rx_sh_q, rx_sh_d;
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic [15:0] rx_div_q, rx_div_d;
	logic rx_busy_q, rx_busy_d;
	logic [9:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_cnt_q, tx_cnt_d;
	logic [15:0] tx_div_q, tx_div_d;
	logic tx_q, tx_d;
	logic wake_q, wake_d;
	logic [15:0] lamp_div_q, lamp_div_d;
	logic [2:0] lamp_step_q, lamp_step_d;
	logic lamp1_q, lamp1_d, lamp2_q, lamp2_d;
	logic acc, wr, rd;
	logic [15:0] pat;

	assign acc = psel & penable & ~pready_q;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;

	always_comb begin
		mode_d = mode_q;
		strap_d = strap_q;
		strap_done_d = 1'b1;
		rom_d = rom_q;
		app_d = app_q;
		ctrl_d = ctrl_q;
		lamp_pat_d = lamp_pat_q;
		prdata_d = prdata_q;
		pready_d = acc;
		pslverr_d = 1'b0;
		rxd_d = rxd_q;
		rx_full_d = rx_full_q;
		rx_sh_d = rx_sh_q;
		rx_cnt_d = rx_cnt_q;
		rx_div_d = rx_div_q;
		rx_busy_d = rx_busy_q;
		tx_sh_d = tx_sh_q;
		tx_cnt_d = tx_cnt_q;
		tx_div_d = tx_div_q;
		tx_d = tx_q;
		wake_d = wake_q;
		lamp_div_d = lamp_div_q;
		lamp_step_d = lamp_step_q;
		lamp1_d = lamp1_q;
		lamp2_d = lamp2_q;
		pat = 16'h0000;
		// first edge after release catches the straps, then frozen
		if (!strap_done_q) begin
			strap_d = strap_in;
			rom_d = strap_in.code_source;
			if (strap_in.code_source && !strap_in.boot_first && !strap_in.boot_second)
				mode_d = HCBS_FLASH;
			else
				mode_d = HCBS_SLEEP;
		end
		app_d = (mode_q != HCBS_FLASH) && strap_done_q;
		// key ignored on the capture edge, else a held key masks flash straps
		if (strap_done_q && mode_q == HCBS_SLEEP && wake_key_input)
			mode_d = HCBS_AWAKE;
		else if (mode_q == HCBS_AWAKE && ctrl_q[0] && !wake_key_input && tx_cnt_q == 4'h0)
			mode_d = HCBS_SLEEP;
		// command receiver, only while awake
		if (!rx_busy_q) begin
			if (!uart_rx && mode_q == HCBS_AWAKE) begin
				rx_busy_d = 1'b1;
				rx_div_d = 16'(BAUD_DIV / 2);
				rx_cnt_d = 4'h0;
			end
		end else if (rx_div_q != 16'h0000) begin
			rx_div_d = rx_div_q - 16'h0001;
		end else begin
			rx_div_d = 16'(BAUD_DIV - 1);
			rx_sh_d = {uart_rx, rx_sh_q[9:1]};
			rx_cnt_d = rx_cnt_q + 4'h1;
			if (rx_cnt_q == 4'h9) begin
				rx_busy_d = 1'b0;
				rxd_d = rx_sh_d[8:1];
				rx_full_d = 1'b1;
			end
		end
		// answer transmitter
		if (tx_cnt_q != 4'h0) begin
			if (tx_div_q != 16'h0000) begin
				tx_div_d = tx_div_q - 16'h0001;
			end else begin
				tx_div_d = 16'(BAUD_DIV - 1);
				tx_d = tx_sh_q[0];
				tx_sh_d = {1'b1, tx_sh_q[9:1]};
				tx_cnt_d = tx_cnt_q - 4'h1;
			end
		end
		if (tx_cnt_q == 4'h0 && tx_div_q == 16'h0000)
			tx_d = 1'b1;
		// host wake while an answer pends or software asks
		wake_d = ctrl_q[1] | (tx_cnt_q != 4'h0);
		// lamp stepping
		if (lamp_div_q == 16'h0000) begin
			lamp_div_d = 16'(LAMP_DIV - 1);
			lamp_step_d = lamp_step_q + 3'h1;
		end else begin
			lamp_div_d = lamp_div_q - 16'h0001;
		end
		if (ctrl_q[4:2] <= 3'h6)
			pat = lamp_pat_q[ctrl_q[4:2]];
		lamp1_d = pat[{1'b0, lamp_step_q}];
		lamp2_d = pat[{1'b1, lamp_step_q}];
		// apb access
		if (wr) begin
			case (paddr)
				`HCBS_OFS_CTRL: ctrl_d = pwdata[4:0];
				`HCBS_OFS_LAMP: lamp_pat_d[pwdata[18:16]] = pwdata[15:0];
				`HCBS_OFS_TXD: begin
					if (tx_cnt_q == 4'h0) begin
						tx_sh_d = {1'b1, pwdata[7:0], 1'b0};
						tx_cnt_d = 4'hA;
						tx_div_d = 16'(BAUD_DIV - 1);
					end else begin
						pslverr_d = 1'b1;
					end
				end
				default: pslverr_d = 1'b1;
			endcase
		end
		if (rd) begin
			case (paddr)
				`HCBS_OFS_CTRL: prdata_d = {27'h0, ctrl_q};
				`HCBS_OFS_STAT: prdata_d = {23'h0, tx_cnt_q != 4'h0, rx_full_q, strap_q, rom_q, mode_q};
				`HCBS_OFS_RXD: begin
					prdata_d = {24'h0, rxd_q};
					// a byte landing in this cycle keeps the flag set
					if (!(rx_busy_q && rx_div_q == 16'h0000 && rx_cnt_q == 4'h9))
						rx_full_d = 1'b0;
				end
				default: begin
					prdata_d = 32'h0;
					pslverr_d = 1'b1;
				end
			endcase
		end
	end

	// async low reset from the module reset pin; hold is the host's job
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= HCBS_SLEEP;
			strap_q <= '1;
			strap_done_q <= 1'b0;
			rom_q <= 1'b1;
			app_q <= 1'b0;
			ctrl_q <= 5'h00;
			for (int i = 0; i < 7; i++)
				lamp_pat_q[i] <= 16'h0000;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			rxd_q <= 8'h00;
			rx_full_q <= 1'b0;
			rx_sh_q <= 10'h000;
			rx_cnt_q <= 4'h0;
			rx_div_q <= 16'h0000;
			rx_busy_q <= 1'b0;
			tx_sh_q <= 10'h3FF;
			tx_cnt_q <= 4'h0;
			tx_div_q <= 16'h0000;
			tx_q <= 1'b1;
			wake_q <= 1'b0;
			lamp_div_q <= 16'h0000;
			lamp_step_q <= 3'h0;
			lamp1_q <= 1'b0;
			lamp2_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			strap_q <= strap_d;
			strap_done_q <= strap_done_d;
			rom_q <= rom_d;
			app_q <= app_d;
			ctrl_q <= ctrl_d;
			lamp_pat_q <= lamp_pat_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			rxd_q <= rxd_d;
			rx_full_q <= rx_full_d;
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			rx_div_q <= rx_div_d;
			rx_busy_q <= rx_busy_d;
			tx_sh_q <= tx_sh_d;
			tx_cnt_q <= tx_cnt_d;
			tx_div_q <= tx_div_d;
			tx_q <= tx_d;
			wake_q <= wake_d;
			lamp_div_q <= lamp_div_d;
			lamp_step_q <= lamp_step_d;
			lamp1_q <= lamp1_d;
			lamp2_q <= lamp2_d;
		end
	end

	assign uart_tx = tx_q;
	assign host_wake_output = wake_q;
	assign rom_mode = rom_q;
	assign application_run_mode = app_q;
	assign status_lamp_one = lamp1_q;
	assign status_lamp_two = lamp2_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	a_strap_flash_mode: assert property (@(posedge clock) disable iff (!rst_b)
		(!strap_done_q && strap_in == 3'b001) |=> mode_q == HCBS_FLASH)
		else $error("flash strap combination did not select flash mode");
	a_strap_hold: assert property (@(posedge clock) disable iff (!rst_b)
		strap_done_q |=> $stable(strap_q) && $stable(rom_q))
		else $error("strap value changed after capture");
	a_wake_leaves_sleep: assert property (@(posedge clock) disable iff (!rst_b)
		(strap_done_q && mode_q == HCBS_SLEEP && wake_key_input) |=> mode_q == HCBS_AWAKE)
		else $error("wake key did not leave sleep");
	a_host_wake_tx: assert property (@(posedge clock) disable iff (!rst_b)
		(tx_cnt_q != 4'h0) |=> host_wake_output)
		else $error("host wake low while answer pending");
	a_rx_byte_flag: assert property (@(posedge clock) disable iff (!rst_b)
		(rx_busy_q && rx_div_q == 16'h0000 && rx_cnt_q == 4'h9) |=> rx_full_q && !rx_busy_q)
		else $error("received byte not flagged");
	a_code_source: assert property (@(posedge clock) disable iff (!rst_b)
		strap_done_q |-> rom_q == strap_q.code_source)
		else $error("code source output disagrees with strap");
	a_app_flag: assert property (@(posedge clock) disable iff (!rst_b)
		strap_done_q && mode_q != HCBS_FLASH |=> ##1 application_run_mode || mode_q == HCBS_FLASH)
		else $error("application mode flag missing");
	a_reset_values: assert property (@(posedge clock)
		!rst_b |-> !pready && host_wake_output == 1'b0 && mode_q == HCBS_SLEEP)
		else $error("outputs not at reset values");
	a_apb_one_wait: assert property (@(posedge clock) disable iff (!rst_b)
		(psel && penable && !pready) |=> pready)
		else $error("apb answer late");
endmodule : hcbs_top

// >>> hcbs_host.sv
// Purpose: host microcontroller model for hcbs_top
// Assumes: 8N1 serial at BAUD_DIV clocks per bit
// Notes: serial line idles high between frames
`timescale 1ns/1ps
module hcbs_host #(
	parameter int BAUD_DIV = 4
) (
	input wire logic clock,
	input wire logic uart_tx,
	output logic rst_b,
	output logic uart_rx,
	output logic wake_key_input
);
	// starts high; first pulse gives a clean falling edge, no time-zero race
	initial begin
		rst_b = 1'b1;
		uart_rx = 1'b1;
		wake_key_input = 1'b0;
	end
	// whole cycles low; at 40 ns per cycle two or more clear the minimum pulse
	task reset_pulse(input int cyc);
		@(posedge clock) rst_b <= 1'b0;
		repeat (cyc) @(posedge clock);
		rst_b <= 1'b1;
	endtask : reset_pulse
	task wake(input logic v);
		@(posedge clock) wake_key_input <= v;
	endtask : wake
	task send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock) uart_rx <= f[i];
			repeat (BAUD_DIV - 1) @(posedge clock);
		end
	endtask : send_byte
	// samples mid bit; start seen up to one cycle late
	task recv_byte(output logic [7:0] b);
		int n;
		n = 0;
		while (uart_tx !== 1'b0 && n < 200) begin
			@(posedge clock);
			n++;
		end
		repeat (BAUD_DIV + BAUD_DIV / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			b[i] = uart_tx;
			repeat (BAUD_DIV) @(posedge clock);
		end
	endtask : recv_byte
endmodule : hcbs_host

// >>> hcbs_top_bench.sv
// Purpose: self-checking bench for hcbs_top
// Assumes: short BAUD_DIV and LAMP_DIV to keep the run brief
// Notes: host model owns reset, serial input and wake key
`timescale 1ns/1ps
`include "hcbs_cfg.svh"
module hcbs_top_bench;
	import hcbs_pkg::*;
	logic clock, rst_b, uart_rx, uart_tx, wake_key_input, host_wake_output;
	logic rom_mode, application_run_mode, status_lamp_one, status_lamp_two;
	logic psel, penable, pwrite, pready, pslverr, er, lamp_prev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] rx;
	hcbs_strap_t strap_in;
	hcbs_strap_t tab [3] = '{3'b001, 3'b011, 3'b110};
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	hcbs_top #(.BAUD_DIV(4), .LAMP_DIV(2)) u_dut (.clock(clock), .rst_b(rst_b), .uart_rx(uart_rx),
		.uart_tx(uart_tx), .wake_key_input(wake_key_input), .host_wake_output(host_wake_output),
		.strap_in(strap_in), .rom_mode(rom_mode), .application_run_mode(application_run_mode),
		.status_lamp_one(status_lamp_one), .status_lamp_two(status_lamp_two), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	hcbs_host #(.BAUD_DIV(4)) u_host (.clock(clock), .uart_tx(uart_tx), .rst_b(rst_b),
		.uart_rx(uart_rx), .wake_key_input(wake_key_input));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// run needs a few hundred cycles; ceiling well above
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock) penable <= 1'b1;
		@(posedge clock);
		// only the bench ceiling ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		strap_in = 3'b111;
		u_host.reset_pulse(16);
		repeat (3) @(negedge clock);
		check(application_run_mode, 1'b1);
		check(rom_mode, 1'b1);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd, 32'h00000079);
		apb(1'b0, 12'h0FC, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h00000000);
		$display("test defaults done");
		u_host.wake(1'b1);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd[2:0], 3'b010);
		u_host.send_byte(8'hA5);
		repeat (6) @(posedge clock);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd[7], 1'b1);
		apb(1'b0, `HCBS_OFS_RXD, 32'h0);
		check(rd, 32'h000000A5);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd[7], 1'b0);
		$display("test command in done");
		fork
			begin
				apb(1'b1, `HCBS_OFS_TXD, 32'h0000003C);
				repeat (2) @(negedge clock);
				check(host_wake_output, 1'b1);
				apb(1'b1, `HCBS_OFS_TXD, 32'h00000055);
				check(er, 1'b1);
			end
			u_host.recv_byte(rx);
		join
		check(rx, 8'h3C);
		repeat (20) @(negedge clock);
		check(host_wake_output, 1'b0);
		apb(1'b1, `HCBS_OFS_CTRL, 32'h00000002);
		repeat (2) @(negedge clock);
		check(host_wake_output, 1'b1);
		$display("test answer and wake done");
		for (int i = 0; i < 7; i++) begin
			// alternate lamps per index so a wrong index select shows
			apb(1'b1, `HCBS_OFS_LAMP, {13'h0, i[2:0], (i[0] ? 16'hFF00 : 16'h00FF)});
			apb(1'b1, `HCBS_OFS_CTRL, {27'h0, i[2:0], 2'b00});
			repeat (40) @(negedge clock);
			check({status_lamp_one, status_lamp_two}, i[0] ? 2'b01 : 2'b10);
		end
		apb(1'b1, `HCBS_OFS_LAMP, 32'h00005555);
		apb(1'b1, `HCBS_OFS_CTRL, 32'h00000000);
		repeat (8) @(negedge clock);
		lamp_prev = status_lamp_one;
		repeat (2) @(negedge clock);
		check(status_lamp_one, !lamp_prev);
		check(status_lamp_two, !lamp_prev);
		$display("test lamps done");
		u_host.wake(1'b0);
		apb(1'b1, `HCBS_OFS_CTRL, 32'h00000001);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd[2:0], 3'b001);
		u_host.send_byte(8'h5A);
		repeat (6) @(posedge clock);
		apb(1'b0, `HCBS_OFS_STAT, 32'h0);
		check(rd[7], 1'b0);
		$display("test sleep done");
		foreach (tab[k]) begin
			@(posedge clock) strap_in <= tab[k];
			u_host.reset_pulse(2);
			repeat (2) @(posedge clock);
			strap_in <= ~tab[k];
			repeat (3) @(negedge clock);
			check(application_run_mode, tab[k] != 3'b001);
			check(rom_mode, tab[k][0]);
			apb(1'b0, `HCBS_OFS_STAT, 32'h0);
			check(rd[2:0], (tab[k] == 3'b001) ? 3'b100 : 3'b001);
		end
		$display("test straps done");
		end_of_test();
	end
endmodule : hcbs_top_bench
